// *** rtl/asp_pin_iface.sv ***
// Purpose: serial port, interrupt/modulator pin and clock pin logic
// Assumes: all pins synchronous to clk_i; master clock internal = clk_i/2
// Notes: serial clock is sampled, not used as a clock
`timescale 1ns/1ps
`include "asp_params.svh"
module asp_pin_iface
  import asp_pkg::*;
#(
  parameter logic [1:0] DEV_ADDR = `ASP_DEV_ADDR
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Serial port pins
  input wire logic spi_cs_n_i,
  input wire logic spi_sck_i,
  input wire logic spi_sdi_i,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_o,
  // Interrupt or modulator pin
  input wire logic irq_n_pin_i,
  output logic irq_n_o,
  output logic irq_n_oe_o,
  // Clock pin
  input wire logic mclk_pin_i,
  output logic mclk_o,
  output logic mclk_oe_o,
  // Configuration
  input wire logic [1:0] irq_mode_i,
  input wire logic [1:0] clk_sel_i,
  input wire logic [1:0] prescale_i,
  input wire logic [1:0] data_format_i,
  input wire logic vref_sel_i,
  input wire logic scan_mode_i,
  input wire logic [7:0] input_select_register_i,
  input wire logic [7:0] scan_select_i,
  // Converter core events and data
  input wire logic por_irq_i,
  input wire logic crc_irq_i,
  input wire logic conv_irq_i,
  input wire logic mod_bit_i,
  input wire logic result_valid_i,
  input wire logic [24:0] result_data_i,
  output logic result_ready_o,
  // Core controls and status
  output logic [3:0] mux_pos_o,
  output logic [3:0] mux_neg_o,
  output logic vref_out_en_o,
  output logic analog_master_clock_o,
  output logic irq_idle_high_o,
  output logic [7:0] cmd_o,
  output logic cmd_valid_o,
  output logic [7:0] wr_data_o,
  output logic wr_valid_o
);
  function automatic logic [23:0] fmt_result(input logic [24:0] r, input logic [1:0] f);
    if (r[24] == r[23])
      return r[23:0];
    if (f != `ASP_FMT_SAT)
      return `ASP_OVL_CODE;
    return r[24] ? `ASP_NEG_FULL : `ASP_POS_FULL;
  endfunction

  function automatic logic [2:0] pre_last(input logic [1:0] p);
    return 3'((4'h1 << p) - 4'h1);
  endfunction

  logic cs_q, sck_q, sck_d, sdi_q, mclk_q, mclk_d;
  logic sck_rise, sck_fall, push, pop, reload;
  logic f_valid;
  logic [23:0] f_data;
  logic [7:0] shin;
  asp_state_t st, next_st;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [7:0] in_sh, next_in_sh;
  logic [23:0] out_sh, next_out_sh;
  logic rise_seen, next_rise_seen, addr_bad, next_addr_bad;
  logic next_sdo, next_sdo_oe, next_cmd_valid, next_wr_valid;
  logic [7:0] next_cmd, next_wr_data;

  // Pins taken as synchronous; one stage for edge detection
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cs_q <= 1'b1;
      sck_q <= 1'b0;
      sck_d <= 1'b0;
      sdi_q <= 1'b0;
      mclk_q <= 1'b0;
      mclk_d <= 1'b0;
    end
    else
    begin
      cs_q <= spi_cs_n_i;
      sck_q <= spi_sck_i;
      sck_d <= sck_q;
      sdi_q <= spi_sdi_i;
      mclk_q <= mclk_pin_i;
      mclk_d <= mclk_q;
    end
  end

  assign sck_rise = sck_q & ~sck_d;
  assign sck_fall = ~sck_q & sck_d;
  assign push = result_valid_i & result_ready_o;
  assign shin = {in_sh[6:0], sdi_q};

  asp_fifo #(
    .WIDTH(`ASP_FIFO_WIDTH),
    .DEPTH(`ASP_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(result_valid_i),
    .in_data_i(fmt_result(result_data_i, data_format_i)),
    .in_ready_o(result_ready_o),
    .out_valid_o(f_valid),
    .out_data_o(f_data),
    .out_ready_i(pop)
  );

  always_comb
  begin
    next_st = st;
    next_bit_cnt = bit_cnt;
    next_in_sh = in_sh;
    next_out_sh = out_sh;
    next_rise_seen = rise_seen;
    next_addr_bad = addr_bad;
    next_sdo = spi_sdo_o;
    next_sdo_oe = spi_sdo_oe_o;
    next_cmd = cmd_o;
    next_cmd_valid = 1'b0;
    next_wr_data = wr_data_o;
    next_wr_valid = 1'b0;
    reload = 1'b0;
    pop = 1'b0;
    if (cs_q)
    begin
      // Select high ends any transfer and parks the port
      next_st = ST_IDLE;
      next_sdo_oe = 1'b0;
      next_rise_seen = 1'b0;
      next_bit_cnt = '0;
      next_addr_bad = 1'b0;
    end
    else
    begin
      // In mode 1,1 the first fall precedes any rise and must not shift
      if (sck_rise)
        next_rise_seen = 1'b1;
      unique case (st)
        ST_IDLE:
          next_st = ST_CMD;
        ST_CMD:
        begin
          if (sck_rise)
          begin
            next_in_sh = shin;
            next_bit_cnt = bit_cnt + 5'd1;
            if (bit_cnt == `ASP_ADDR_BITS - 5'd1)
              next_addr_bad = shin[1:0] != DEV_ADDR;
            if (bit_cnt == `ASP_CMD_BITS - 5'd1)
            begin
              next_bit_cnt = '0;
              next_cmd = shin;
              next_cmd_valid = !addr_bad;
              next_sdo_oe = 1'b0;
              if (addr_bad)
                next_st = ST_SINK;
              else if (shin[`ASP_CMD_TYPE_HI:`ASP_CMD_TYPE_LO] == `ASP_CMD_READ)
              begin
                next_st = ST_READ;
                next_sdo_oe = spi_sdo_oe_o;
                reload = 1'b1;
              end
              else if (shin[`ASP_CMD_TYPE_HI:`ASP_CMD_TYPE_LO] == `ASP_CMD_WRITE)
                next_st = ST_WRITE;
              else
                next_st = ST_SINK;
            end
          end
          else if (sck_fall && rise_seen)
          begin
            // Status bit: a result is waiting
            next_sdo = f_valid;
            next_sdo_oe = !addr_bad && (bit_cnt >= `ASP_ADDR_BITS);
          end
        end
        ST_READ:
        begin
          // Input shifter left untouched while reading
          if (sck_fall)
          begin
            next_sdo = out_sh[23];
            next_sdo_oe = 1'b1;
            next_out_sh = {out_sh[22:0], 1'b0};
            next_bit_cnt = bit_cnt + 5'd1;
            if (bit_cnt == `ASP_WORD_BITS - 5'd1)
            begin
              next_bit_cnt = '0;
              reload = 1'b1;
            end
          end
        end
        ST_WRITE:
        begin
          next_sdo_oe = 1'b0;
          if (sck_rise)
          begin
            next_in_sh = shin;
            next_bit_cnt = bit_cnt + 5'd1;
            if (bit_cnt == `ASP_CMD_BITS - 5'd1)
            begin
              next_bit_cnt = '0;
              next_wr_data = shin;
              next_wr_valid = 1'b1;
            end
          end
        end
        ST_SINK:
          next_sdo_oe = 1'b0;
        default:
          next_st = ST_IDLE;
      endcase
    end
    // An empty buffer reads as zeros rather than stalling the host
    if (reload)
    begin
      pop = f_valid;
      next_out_sh = f_valid ? f_data : 24'h0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st <= ST_IDLE;
      bit_cnt <= '0;
      in_sh <= 8'h0;
      out_sh <= 24'h0;
      rise_seen <= 1'b0;
      addr_bad <= 1'b0;
      spi_sdo_o <= 1'b0;
      spi_sdo_oe_o <= 1'b0;
      cmd_o <= 8'h0;
      cmd_valid_o <= 1'b0;
      wr_data_o <= 8'h0;
      wr_valid_o <= 1'b0;
    end
    else
    begin
      st <= next_st;
      bit_cnt <= next_bit_cnt;
      in_sh <= next_in_sh;
      out_sh <= next_out_sh;
      rise_seen <= next_rise_seen;
      addr_bad <= next_addr_bad;
      spi_sdo_o <= next_sdo;
      spi_sdo_oe_o <= next_sdo_oe;
      cmd_o <= next_cmd;
      cmd_valid_o <= next_cmd_valid;
      wr_data_o <= next_wr_data;
      wr_valid_o <= next_wr_valid;
    end
  end

  // Master clock edges and analog clock divider
  logic mclk_edge, am_rise, mod_q, next_am, next_mod, next_mclk_oe;
  logic [2:0] div_cnt, next_div;
  logic hard, active, next_irq, next_irq_oe, next_idle_high;
  logic [2:0] drdy_cnt, next_drdy;
  logic [3:0] next_pos, next_neg;

  always_comb
  begin
    // Internal clock gives two edges per master period
    mclk_edge = clk_sel_i[`ASP_CLK_INT_BIT] ? 1'b1 : (mclk_q ^ mclk_d);
    next_div = div_cnt;
    next_am = analog_master_clock_o;
    am_rise = 1'b0;
    if (mclk_edge)
    begin
      if (div_cnt >= pre_last(prescale_i))
      begin
        next_div = 3'h0;
        next_am = !analog_master_clock_o;
        am_rise = !analog_master_clock_o;
      end
      else
        next_div = div_cnt + 3'h1;
    end
    next_mod = am_rise ? mod_bit_i : mod_q;
    next_mclk_oe = clk_sel_i == `ASP_CLK_SEL_ANA_OUT;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      div_cnt <= 3'h0;
      analog_master_clock_o <= 1'b0;
      mod_q <= 1'b0;
      mclk_o <= 1'b0;
      mclk_oe_o <= 1'b0;
    end
    else
    begin
      div_cnt <= next_div;
      analog_master_clock_o <= next_am;
      mod_q <= next_mod;
      mclk_o <= analog_master_clock_o;
      mclk_oe_o <= next_mclk_oe;
    end
  end

  // Interrupt pin and core selects
  always_comb
  begin
    hard = por_irq_i | crc_irq_i;
    next_drdy = drdy_cnt;
    if (drdy_cnt != 3'h0)
      next_drdy = drdy_cnt - 3'h1;
    if (push)
      next_drdy = `ASP_DRDY_CYC;
    active = hard | conv_irq_i | (drdy_cnt != 3'h0);
    if (irq_mode_i[`ASP_IRQ_FN_BIT])
    begin
      // Power-on and CRC interrupts still override the bitstream
      next_irq = hard ? 1'b0 : mod_q;
      next_irq_oe = 1'b1;
    end
    else if (active)
    begin
      next_irq = 1'b0;
      next_irq_oe = 1'b1;
    end
    else
    begin
      next_irq = 1'b1;
      next_irq_oe = irq_mode_i[`ASP_IRQ_IDLE_BIT];
    end
    // Only meaningful while we are not pulling the pin low
    next_idle_high = irq_n_o ? irq_n_pin_i : irq_idle_high_o;
    next_pos = scan_mode_i ? scan_select_i[7:4] : input_select_register_i[7:4];
    next_neg = scan_mode_i ? scan_select_i[3:0] : input_select_register_i[3:0];
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      drdy_cnt <= 3'h0;
      irq_n_o <= 1'b1;
      irq_n_oe_o <= 1'b0;
      irq_idle_high_o <= 1'b1;
      mux_pos_o <= 4'h0;
      mux_neg_o <= 4'h0;
      vref_out_en_o <= 1'b0;
    end
    else
    begin
      drdy_cnt <= next_drdy;
      irq_n_o <= next_irq;
      irq_n_oe_o <= next_irq_oe;
      irq_idle_high_o <= next_idle_high;
      mux_pos_o <= next_pos;
      mux_neg_o <= next_neg;
      vref_out_en_o <= vref_sel_i;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_cs_high_tri: assert property (
    cs_q |=> !spi_sdo_oe_o) else $error("sdo driven with select high");
  a_addr_mismatch_tri: assert property (
    addr_bad && !cs_q |=> !spi_sdo_oe_o) else $error("sdo driven on address mismatch");
  a_write_tri: assert property (
    st == ST_WRITE || st == ST_SINK |-> !spi_sdo_oe_o) else $error("sdo driven in write");
  a_read_ignores_sdi: assert property (
    st == ST_READ && !cs_q |=> $stable(in_sh)) else $error("sdi used during read");
  a_sample_rise: assert property (
    st == ST_CMD && !cs_q && sck_rise |=> in_sh[0] == $past(sdi_q))
    else $error("sdi not sampled on rise");
  a_shift_fall: assert property (
    st == ST_READ && !cs_q && sck_fall |=> spi_sdo_o == $past(out_sh[23]))
    else $error("sdo not shifted on fall");
  a_hard_irq_low: assert property (
    hard |=> !irq_n_o && irq_n_oe_o) else $error("pin not low on por or crc");
  a_drdy_pulse: assert property (
    push ##1 !irq_mode_i[`ASP_IRQ_FN_BIT] |=> !irq_n_o) else $error("no data ready pulse");
  a_irq_idle_hiz: assert property (
    !active && irq_mode_i == 2'h0 |=> !irq_n_oe_o && irq_n_o) else $error("idle pin not high-z");
  a_ana_clk_pin: assert property (
    clk_sel_i == `ASP_CLK_SEL_ANA_OUT |=> mclk_oe_o && mclk_o == $past(analog_master_clock_o))
    else $error("analog clock not on pin");
  a_mux_scan: assert property (
    scan_mode_i ##1 scan_mode_i |-> mux_neg_o == $past(scan_select_i[3:0]))
    else $error("sequencer select not applied");
endmodule

// *** rtl/asp_params.svh ***
// Purpose: constants for the converter pin interface block
// Assumes: 40 MHz clk_i, pins synchronous to clk_i
// Notes: types live in asp_pkg
// Behaviour
// - Chip select falling starts a transaction, rising ends it.
// - Chip select high: ignore clock and data, no transfer.
// - Serial input bits are sampled on serial clock rising edges.
// - Serial output bits change on serial clock falling edges.
// - Works with clock idling low (0,0) or high (1,1).
// - Serial clock and master clock are unrelated; master clock runs continuously.
// - Output tri-stated with select high and through write or fast commands.
// - Output stays tri-stated when the two address bits mismatch.
// - Serial input transitions are ignored during a read.
// - Mode upper bit selects interrupts (0, default) or modulator data.
// - Mode lower bit selects inactive level: high-Z or driven high.
// - Modulator data leaves synchronous to the analog master clock.
// - Pending power-on or CRC interrupt holds the pin low until cleared.
// - Pin level is read back; it must read high when idle.
// - Clock select decides clock pin input or analog clock output.
// - Analog master clock is master clock divided by prescale factor.
// - Channel selects come from direct register or sequencer register.
// - Reference select 1 drives internal reference onto positive pin.
// - Out-of-range results saturate or carry overload code per format.
// - Each new result gives a data-ready pulse on the interrupt pin. Pulsed only with mode upper bit 0; modulator mode gives none.
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH

// Arbitrary neutral device address
`define ASP_DEV_ADDR 2'h1
`define ASP_CMD_TYPE_HI 1
`define ASP_CMD_TYPE_LO 0
`define ASP_CMD_READ 2'h1
`define ASP_CMD_WRITE 2'h2
`define ASP_ADDR_BITS 5'd2
`define ASP_CMD_BITS 5'd8
`define ASP_WORD_BITS 5'd24

`define ASP_IRQ_FN_BIT 1
`define ASP_IRQ_IDLE_BIT 0
`define ASP_CLK_INT_BIT 1
`define ASP_CLK_SEL_ANA_OUT 2'h3

`define ASP_FMT_SAT 2'h0
`define ASP_POS_FULL 24'h7fffff
`define ASP_NEG_FULL 24'h800000
`define ASP_OVL_CODE 24'h800000

`define ASP_FIFO_WIDTH 24
`define ASP_FIFO_DEPTH 8

`define ASP_CLK_PERIOD_NS 25
`define ASP_SCK_MAX_MHZ 20
`define ASP_DRDY_PULSE_NS 100
`define ASP_DRDY_CYC \
  3'((`ASP_DRDY_PULSE_NS + `ASP_CLK_PERIOD_NS - 1) / `ASP_CLK_PERIOD_NS)

`endif

// *** rtl/asp_pkg.sv ***
// Purpose: shared types of the pin interface block
// Assumes: nothing
// Notes: constants are in asp_params.svh
package asp_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_READ, ST_WRITE, ST_SINK} asp_state_t;
endpackage

// *** rtl/asp_fifo.sv ***
// Purpose: result buffer between converter core and serial port
// Assumes: single clock
// Notes: read data registered; valid drops one cycle after each pop
`timescale 1ns/1ps
module asp_fifo
#(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
  logic [AW:0] count, next_count;
  logic next_ready, next_valid, push, pop;

  always_comb
  begin
    push = in_valid_i & in_ready_o;
    pop = out_ready_i & out_valid_o & (count != '0);
    next_wptr = push ? AW'(wptr + 1'b1) : wptr;
    next_rptr = pop ? AW'(rptr + 1'b1) : rptr;
    next_count = count;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
    next_ready = next_count != FULL;
    // Hide stale head until it is refetched
    next_valid = (count != '0) && !pop;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      in_ready_o <= 1'b0;
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end
    else
    begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      count <= next_count;
      in_ready_o <= next_ready;
      out_valid_o <= next_valid;
      out_data_o <= mem[rptr];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wptr] <= in_data_i;
  end
endmodule

// *** testbench/asp_spi_host.sv ***
// Purpose: host model that drives the serial port of the pin interface
// Assumes: 5 MHz serial clock, four clk_i periods per level
// Notes: received words are queued in rxq, 24 bits each
`timescale 1ns/1ps
module asp_spi_host
(
  // Clock
  input wire logic clk_i,
  // Serial pins
  output logic cs_n_o,
  output logic sck_o,
  output logic sdi_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_i
);
  logic sdi_q = 1'b0;
  logic tog = 1'b0;
  logic oe_hit = 1'b0;
  logic [23:0] rxq[$];
  initial
  begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
  end
  always @(posedge clk_i)
    tog <= ~tog;
  // Deselected data line must not hold a stale level
  assign sdi_o = cs_n_o ? tog : sdi_q;
  task automatic xfer(input logic cpol, input logic [7:0] cmd, input int n,
                      input logic [23:0] tx);
    logic [23:0] rx;
    int i;
    rx = '0;
    oe_hit = 1'b0;
    @(posedge clk_i);
    sck_o <= cpol;
    repeat (2) @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    for (i = 0; i < 8 + n; i++)
    begin
      sdi_q <= (i < 8) ? cmd[7 - i] : tx[23 - (i - 8) % 24];
      sck_o <= 1'b0;
      // Slow levels leave room for the two-edge output lag
      repeat (4) @(posedge clk_i);
      if (i >= 8)
      begin
        oe_hit = oe_hit | sdo_oe_i;
        rx = {rx[22:0], sdo_oe_i ? sdo_i : ~rx[0]};
        if ((i - 7) % 24 == 0)
          rxq.push_back(rx);
      end
      sck_o <= 1'b1;
      repeat (4) @(posedge clk_i);
    end
    sck_o <= cpol;
    repeat (2) @(posedge clk_i);
    cs_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// *** testbench/tb_asp_pin_iface.sv ***
// Purpose: self-checking bench of the converter pin interface
// Assumes: 40 MHz clk_i, host model on the serial pins
// Notes: irq pin has a pull-up; clock pin fed by a toggling source
`timescale 1ns/1ps
`include "asp_params.svh"
module tb_asp_pin_iface;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic cs_n, sck, sdi, sdo, sdo_oe, irq_n, irq_oe, mclk, mclk_oe, pin_tog = 1'b0;
  logic [1:0] irq_mode = 2'h0, clk_sel = 2'h0, prescale = 2'h0, fmt = 2'h0;
  logic vref_sel = 1'b0, scan_mode = 1'b0, por = 1'b0, crc = 1'b0, mod_bit = 1'b0;
  logic res_valid = 1'b0, res_ready, vref_en, ana_clk, idle_hi, cmd_v, wr_v, last, seen;
  // Third interrupt source, and a board fault that drags the shared pin low
  logic conv = 1'b0, pin_low = 1'b0;
  logic [24:0] res_data = '0;
  logic [7:0] in_sel = 8'h00, scan_sel = 8'h00, cmd, wr_data, cmd_seen = 8'h00;
  logic [7:0] wr_seen = 8'h00;
  logic [3:0] mpos, mneg;
  int error_cnt = 0, compares = 0, cmd_cnt = 0, k, tg, c0, mc;

  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    pin_tog <= ~pin_tog;
    if (cmd_v)
      cmd_cnt <= cmd_cnt + 1;
    if (cmd_v)
      cmd_seen <= cmd;
    if (wr_v)
      wr_seen <= wr_data;
  end

  asp_spi_host asp_spi_host_i (.clk_i(clk_i), .cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi),
    .sdo_i(sdo), .sdo_oe_i(sdo_oe));

  asp_pin_iface asp_pin_iface_i (.clk_i(clk_i), .resetn_i(resetn_i), .spi_cs_n_i(cs_n),
    .spi_sck_i(sck), .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe),
    .irq_n_pin_i(pin_low ? 1'b0 : irq_oe ? irq_n : 1'b1), .irq_n_o(irq_n), .irq_n_oe_o(irq_oe),
    .mclk_pin_i(pin_tog), .mclk_o(mclk), .mclk_oe_o(mclk_oe), .irq_mode_i(irq_mode),
    .clk_sel_i(clk_sel), .prescale_i(prescale), .data_format_i(fmt),
    .vref_sel_i(vref_sel), .scan_mode_i(scan_mode), .input_select_register_i(in_sel),
    .scan_select_i(scan_sel), .por_irq_i(por), .crc_irq_i(crc), .conv_irq_i(conv),
    .mod_bit_i(mod_bit), .result_valid_i(res_valid), .result_data_i(res_data),
    .result_ready_o(res_ready), .mux_pos_o(mpos), .mux_neg_o(mneg),
    .vref_out_en_o(vref_en), .analog_master_clock_o(ana_clk), .irq_idle_high_o(idle_hi),
    .cmd_o(cmd), .cmd_valid_o(cmd_v), .wr_data_o(wr_data), .wr_valid_o(wr_v));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic push(input logic [24:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    res_valid <= 1'b1;
    res_data <= d;
    @(posedge clk_i);
    while (res_ready !== 1'b1 && n < 50)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n == 50)
      chk("push_taken", 1, 0);
    res_valid <= 1'b0;
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic rd(input string name, input logic [23:0] exp);
    chk(name, exp, asp_spi_host_i.rxq.size() > 0 ? asp_spi_host_i.rxq.pop_front() : 'x);
  endtask

  task tally_and_finish;
    $display("Compares %0d, errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #1_000_000;
    error_cnt++;
    tally_and_finish;
  end

  initial
  begin
    wait_clk(5);
    resetn_i <= 1'b1;
    wait_clk(3);
    chk("idle_high", 1, idle_hi);
    chk("sdo_oe", 0, sdo_oe);
    in_sel <= 8'h3a;
    scan_sel <= 8'hc5;
    vref_sel <= 1'b1;
    wait_clk(2);
    chk("mux_direct", 8'h3a, {mpos, mneg});
    chk("vref_int", 1, vref_en);
    scan_mode <= 1'b1;
    vref_sel <= 1'b0;
    wait_clk(2);
    chk("mux_scan", 8'hc5, {mpos, mneg});
    chk("vref_ext", 0, vref_en);
    irq_mode <= 2'h1;
    wait_clk(2);
    chk("irq_idle", 2'b11, {irq_oe, irq_n});
    por <= 1'b1;
    wait_clk(2);
    chk("irq_por", 2'b10, {irq_oe, irq_n});
    por <= 1'b0;
    irq_mode <= 2'h0;
    wait_clk(2);
    chk("irq_hiz", 0, irq_oe);
    chk("idle_high", 1, idle_hi);
    pin_low <= 1'b1;
    wait_clk(2);
    chk("idle_low", 0, idle_hi);
    pin_low <= 1'b0;
    conv <= 1'b1;
    wait_clk(2);
    chk("idle_back", 1, idle_hi);
    chk("irq_conv", 2'b10, {irq_oe, irq_n});
    // Conversion interrupt stays high: it must not block the bitstream
    irq_mode <= 2'h2;
    clk_sel <= 2'h3;
    mod_bit <= 1'b1;
    wait_clk(40);
    chk("modbit_one", 1, irq_n);
    chk("mclk_oe", 1, mclk_oe);
    mod_bit <= 1'b0;
    conv <= 1'b0;
    wait_clk(40);
    chk("modbit_zero", 0, irq_n);
    mod_bit <= 1'b1;
    crc <= 1'b1;
    wait_clk(40);
    chk("modbit_crc", 0, irq_n);
    crc <= 1'b0;
    wait_clk(40);
    chk("modbit_free", 1, irq_n);
    // Count divided clock toggles over a fixed span per prescale code
    for (k = 0; k < 4; k++)
    begin
      prescale <= 2'(k);
      wait_clk(20);
      tg = 0;
      mc = 0;
      last = ana_clk;
      repeat (64)
      begin
        @(posedge clk_i);
        // Clock pin repeats the divided clock one cycle later
        mc += (mclk !== last);
        tg += (ana_clk !== last);
        last = ana_clk;
      end
      chk("ana_clk_div", 1, tg >= (64 >> k) - 1 && tg <= (64 >> k) + 1);
      chk("mclk_out", 0, mc);
    end
    clk_sel <= 2'h0;
    irq_mode <= 2'h1;
    wait_clk(2);
    chk("mclk_in", 0, mclk_oe);
    push(25'h0000123);
    seen = 1'b0;
    repeat (8)
    begin
      @(posedge clk_i);
      seen = seen | (irq_n === 1'b0);
    end
    chk("drdy", 1, seen);
    asp_spi_host_i.xfer(1'b0, 8'h41, 24, 24'hffffff);
    rd("rd_word", 24'h000123);
    chk("rd_cmd", 8'h41, cmd_seen);
    for (k = 0; k < 8; k++)
      push(k == 6 ? 25'h0800000 : k == 7 ? 25'h17fffff : 25'(k * 'h11111));
    wait_clk(2);
    chk("full_ready", 0, res_ready);
    asp_spi_host_i.xfer(1'b1, 8'h41, 192, 24'h5a5a5a);
    for (k = 0; k < 8; k++)
      rd("rd_burst", k == 6 ? `ASP_POS_FULL : k == 7 ? `ASP_NEG_FULL : 24'(k * 'h11111));
    chk("drained_ready", 1, res_ready);
    fmt <= 2'h1;
    push(25'h0800000);
    asp_spi_host_i.xfer(1'b0, 8'h41, 24, 24'h000000);
    rd("rd_ovl", `ASP_OVL_CODE);
    asp_spi_host_i.xfer(1'b0, 8'h42, 8, 24'ha50000);
    chk("wr_byte", 8'ha5, wr_seen);
    chk("wr_cmd", 8'h42, cmd_seen);
    chk("wr_hiz", 0, asp_spi_host_i.oe_hit);
    asp_spi_host_i.xfer(1'b0, 8'h43, 8, 24'hff0000);
    chk("fast_hiz", 0, asp_spi_host_i.oe_hit);
    chk("fast_cmd", 8'h43, cmd_seen);
    push(25'h0000777);
    c0 = cmd_cnt;
    asp_spi_host_i.xfer(1'b0, 8'h81, 24, 24'h000000);
    chk("addr_hiz", 0, asp_spi_host_i.oe_hit);
    chk("addr_cmd", c0, cmd_cnt);
    asp_spi_host_i.rxq.delete();
    tally_and_finish;
  end
endmodule
